// ==== core/wfcap_defines.svh ====
/*
 Constants for the waveform capture unit: channel counts, capture window timing,
 sample layout and memory depth. Assumes a 40 MHz core clock.
*/
// Contract
// R1 - Compare twelve network currents while charging
// R2 - Over threshold flags prefire fault to supervisor
// R3 - Preionization trigger starts writing samples
// R4 - Record three milliseconds then signal done
// R5 - Capture sixteen analog channels per sample
// R6 - Supervisor reads stored data after shot
// R7 - Keep captured data until read or rearmed
`ifndef WFCAP_DEFINES_SVH
`define WFCAP_DEFINES_SVH
`define WFCAP_NUM_CH 16
`define WFCAP_NUM_NET 12
`define WFCAP_SAMPLE_W 12
`define WFCAP_CLK_HZ 40000000
`define WFCAP_WINDOW_US 3000
`define WFCAP_WINDOW_CYC ((`WFCAP_WINDOW_US * (`WFCAP_CLK_HZ / 1000000)))
`define WFCAP_SAMPLE_DIV 1200
`define WFCAP_DEPTH 100
`define WFCAP_ADDR_W 11
`endif

// ==== core/wfcap_pkg.sv ====
/*
 Types shared by the waveform capture unit.
 Assumes the defines header is compiled first.
*/
package wfcap_pkg;
    typedef enum logic [1:0] {WFCAP_IDLE, WFCAP_CHARGE, WFCAP_RECORD, WFCAP_HOLD} wfcap_state_t;
endpackage

// ==== core/wfcap_skid.sv ====
/*
 Two-entry buffer with valid/ready on both sides.
 Assumes a single clock and an active-high async reset.
*/
`timescale 1ns/100ps
`default_nettype none
module wfcap_skid #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [2];
    logic wr_q, rd_q;
    logic [1:0] cnt_q;
    logic push, pop;

    // Handshakes are combinational from the fill count
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage writes need no reset; valid gates the reads
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// ==== core/wfcap_top.sv ====
/*
 Waveform capture unit: prefire monitor on the twelve discharge network channels
 during charging, and a fixed-window capture of all sixteen channels after the
 preionization circuit trigger. Samples are taken at a decimated rate into an
 internal memory that the supervisor reads after the shot through a buffered
 read stream. Assumes converter words arrive synchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wfcap_defines.svh"
module wfcap_top #(
    parameter int NUM_CH = `WFCAP_NUM_CH,
    parameter int NUM_NET = `WFCAP_NUM_NET,
    parameter int SW = `WFCAP_SAMPLE_W,
    parameter int WINDOW_CYC = `WFCAP_WINDOW_CYC,
    parameter int SAMPLE_DIV = `WFCAP_SAMPLE_DIV,
    parameter int DEPTH = `WFCAP_DEPTH,
    parameter int AW = `WFCAP_ADDR_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Conditioning unit sequence
    input wire logic charge_active,
    input wire logic preionization_circuit_trig,
    input wire logic arm,
    // Converter samples, channel c at bits c*SW
    input wire logic [NUM_CH*SW-1:0] sample_in,
    input wire logic [SW-1:0] prefire_threshold,
    // Status to supervisor
    output logic prefire_fault,
    output logic [NUM_NET-1:0] prefire_chan,
    output logic capture_done,
    output logic capture_busy,
    output wfcap_pkg::wfcap_state_t state,
    // Readout stream
    input wire logic read_start,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [SW-1:0] rd_data,
    output logic read_last
);
    import wfcap_pkg::*;

    localparam int TOTAL = DEPTH * NUM_CH;

    wfcap_state_t state_q;
    logic [31:0] win_q;
    logic [31:0] div_q;
    logic [AW-1:0] frame_q;
    logic [SW-1:0] mem [TOTAL];
    logic [NUM_NET-1:0] over;
    logic [NUM_NET-1:0] hit_q;
    logic done_q;
    logic [15:0] rd_idx_q;
    logic reading_q;
    logic fetch_ok;
    logic [SW-1:0] fetch_data_q;
    logic fetch_valid_q;
    logic fetch_ready;
    logic trig_q;
    logic trig_rise;
    logic sample_tick;

    assign state = state_q;
    assign prefire_fault = |hit_q;
    assign prefire_chan = hit_q;
    assign capture_done = done_q;
    assign capture_busy = (state_q == WFCAP_RECORD);
    assign trig_rise = preionization_circuit_trig && !trig_q;
    assign sample_tick = (div_q == 32'h0);

    // R1 compare each network channel
    genvar g;
    generate
        for (g = 0; g < NUM_NET; g++) begin : g_cmp
            assign over[g] = sample_in[g*SW +: SW] > prefire_threshold;
        end
    endgenerate

    // Trigger edge detect so a held trigger starts one capture only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= preionization_circuit_trig;
        end
    end

    // Sequence: idle, charge watch, record window, hold for readout
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= WFCAP_IDLE;
        end else begin
            case (state_q)
                WFCAP_IDLE: begin
                    if (trig_rise) begin
                        state_q <= WFCAP_RECORD;
                    end else if (charge_active) begin
                        state_q <= WFCAP_CHARGE;
                    end
                end
                WFCAP_CHARGE: begin
                    // R3 trigger starts capture
                    if (trig_rise) begin
                        state_q <= WFCAP_RECORD;
                    end else if (!charge_active) begin
                        state_q <= WFCAP_IDLE;
                    end
                end
                WFCAP_RECORD: begin
                    // R4 fixed window end
                    if (win_q == 32'(WINDOW_CYC - 1)) begin
                        state_q <= WFCAP_HOLD;
                    end
                end
                WFCAP_HOLD: begin
                    // R7 held until rearmed
                    if (arm) begin
                        state_q <= WFCAP_IDLE;
                    end
                end
                default: state_q <= WFCAP_IDLE;
            endcase
        end
    end

    // Window and sample-rate counters run only while recording
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            win_q <= 32'h0;
            div_q <= 32'h0;
            frame_q <= '0;
        end else if (state_q == WFCAP_RECORD) begin
            win_q <= win_q + 32'h1;
            div_q <= (div_q == 32'(SAMPLE_DIV - 1)) ? 32'h0 : div_q + 32'h1;
            if (sample_tick && frame_q != AW'(DEPTH)) begin
                frame_q <= frame_q + AW'(1);
            end
        end else if (state_q != WFCAP_HOLD) begin
            win_q <= 32'h0;
            div_q <= 32'h0;
            frame_q <= '0;
        end
    end

    // R5 write all channels per frame; memory is untouched outside recording
    always_ff @(posedge core_clk) begin
        if (state_q == WFCAP_RECORD && sample_tick && frame_q != AW'(DEPTH)) begin
            for (int c = 0; c < NUM_CH; c++) begin
                mem[int'(frame_q) * NUM_CH + c] <= sample_in[c*SW +: SW];
            end
        end
    end

    // R2 sticky prefire flags; a new hit wins over the arm clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hit_q <= '0;
        end else begin
            hit_q <= (arm ? '0 : hit_q) | ((state_q == WFCAP_CHARGE) ? over : '0);
        end
    end

    // R4 done flag held until the next arm
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (state_q == WFCAP_RECORD && win_q == 32'(WINDOW_CYC - 1)) begin
            done_q <= 1'b1;
        end else if (arm) begin
            done_q <= 1'b0;
        end
    end

    // R6 readout walk over the whole memory, stalled by the buffer
    assign fetch_ok = reading_q && (!fetch_valid_q || fetch_ready);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reading_q <= 1'b0;
            rd_idx_q <= 16'h0;
            fetch_valid_q <= 1'b0;
            fetch_data_q <= '0;
        end else begin
            if (fetch_valid_q && fetch_ready) begin
                fetch_valid_q <= 1'b0;
            end
            if (read_start && state_q == WFCAP_HOLD && !reading_q) begin
                reading_q <= 1'b1;
                rd_idx_q <= 16'h0;
            end else if (fetch_ok) begin
                fetch_data_q <= mem[int'(rd_idx_q)];
                fetch_valid_q <= 1'b1;
                rd_idx_q <= rd_idx_q + 16'h1;
                if (rd_idx_q == 16'(TOTAL - 1)) begin
                    reading_q <= 1'b0;
                end
            end
        end
    end

    // Last-word marker travels with the count of words handed out
    logic [15:0] out_cnt_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_cnt_q <= 16'h0;
        end else if (read_start && state_q == WFCAP_HOLD && !reading_q) begin
            out_cnt_q <= 16'h0;
        end else if (rd_valid && rd_ready) begin
            out_cnt_q <= out_cnt_q + 16'h1;
        end
    end
    assign read_last = rd_valid && (out_cnt_q == 16'(TOTAL - 1));

    // Buffer absorbs a reader stall without dropping a fetched word
    wfcap_skid #(.W(SW)) u_skid (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(fetch_valid_q),
        .in_ready(fetch_ready),
        .in_data(fetch_data_q),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
endmodule
`default_nettype wire

// ==== testbench/wfcap_checker_properties.sv ====
/* Port checks for the capture unit: prefire flags, window, stream.
   Assumes binding into wfcap_top, which hands on its counts. */
`timescale 1ns/100ps
`default_nettype none
module wfcap_checker #(
    parameter int NUM_CH = 16,
    parameter int NUM_NET = 12,
    parameter int SW = 12,
    parameter int WINDOW_CYC = 50
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Sequence and samples
    input wire logic preionization_circuit_trig,
    input wire logic arm,
    input wire logic [NUM_CH*SW-1:0] sample_in,
    input wire logic [SW-1:0] prefire_threshold,
    // Status and stream
    input wire logic prefire_fault,
    input wire logic [NUM_NET-1:0] prefire_chan,
    input wire logic capture_done,
    input wire logic capture_busy,
    input wire wfcap_pkg::wfcap_state_t state,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic [SW-1:0] rd_data
);
    import wfcap_pkg::*;
    logic [NUM_NET-1:0] over;
    logic [31:0] cnt_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Strict compare, so a level equal to the threshold is no hit
    always_comb begin
        for (int c = 0; c < NUM_NET; c++)
            over[c] = sample_in[c*SW+:SW] > prefire_threshold;
    end
    // Cycles spent recording; an off-by-one window shows here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) cnt_q <= 32'h0;
        else cnt_q <= (state == WFCAP_RECORD) ? cnt_q + 32'h1 : 32'h0;
    end
    property p_flag;
        state == WFCAP_CHARGE && over != '0 |=> (prefire_chan & $past(over)) == $past(over);
    endproperty
    a_flag: assert property (p_flag) else $error("hit not flagged");
    property p_noflag;
        (prefire_chan & ~$past(prefire_chan)) != '0 |-> $past(state) == WFCAP_CHARGE
            && (prefire_chan & ~$past(prefire_chan) & ~$past(over)) == '0;
    endproperty
    a_noflag: assert property (p_noflag) else $error("flag without hit");
    property p_sticky; ($past(prefire_chan) & ~prefire_chan) != '0 |-> $past(arm); endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_fault; prefire_fault == |prefire_chan; endproperty
    a_fault: assert property (p_fault) else $error("fault not OR of flags");
    property p_trig;
        $rose(preionization_circuit_trig) && state inside {WFCAP_IDLE, WFCAP_CHARGE}
            |=> state == WFCAP_RECORD;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger missed");
    property p_busy; capture_busy == (state == WFCAP_RECORD); endproperty
    a_busy: assert property (p_busy) else $error("busy wrong");
    property p_window; $rose(capture_done) |-> cnt_q == WINDOW_CYC && state == WFCAP_HOLD; endproperty
    a_window: assert property (p_window) else $error("window length wrong");
    property p_done_hold; $fell(capture_done) |-> $past(arm); endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost");
    property p_rd_hold; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("stalled word lost");
endmodule
bind wfcap_top wfcap_checker #(.NUM_CH(NUM_CH), .NUM_NET(NUM_NET), .SW(SW),
    .WINDOW_CYC(WINDOW_CYC)) u_chk (.*);
`default_nettype wire

// ==== testbench/wfcap_supervisor_model.sv ====
/* Supervisor side of the readout stream, with gaps and long stalls.
   Assumes the single core clock and active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module wfcap_supervisor_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Readout stream
    input wire logic rd_valid,
    output logic rd_ready
);
    logic [6:0] cnt_q;
    // reads stored words
    // A sixteen-cycle stall fills the buffer on purpose
    always @(posedge core_clk) begin
        #2;
        cnt_q = rst ? 7'h00 : cnt_q + {6'h00, rd_valid};
        rd_ready = (cnt_q[2:0] != 3'h0) && (cnt_q[6:4] != 3'h5);
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* Bench for the capture unit: prefire flags, capture window, two readouts.
   Assumes shortened window, frame and depth counts set at the instance. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import wfcap_pkg::*;
    localparam int SW = 12;
    logic core_clk, rst, charge_active, trig, arm, read_start;
    logic prefire_fault, capture_done, capture_busy, rd_valid, rd_ready, read_last;
    logic [191:0] sample_in;
    logic [11:0] thr, rd_data, prefire_chan;
    wfcap_state_t state;
    logic [11:0] mem [160];
    logic [15:0] exp_q [$];
    logic [31:0] lfsr;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int k;
    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;
    wfcap_top #(.WINDOW_CYC(50), .SAMPLE_DIV(5), .DEPTH(10)) i_wfcap_top (
        .core_clk, .rst, .charge_active, .preionization_circuit_trig(trig), .arm,
        .sample_in, .prefire_threshold(thr), .prefire_fault, .prefire_chan,
        .capture_done, .capture_busy, .state, .read_start, .rd_valid, .rd_ready,
        .rd_data, .read_last);
    wfcap_supervisor_model i_wfcap_supervisor_model (.core_clk, .rst, .rd_valid, .rd_ready);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic step;
        @(posedge core_clk);
        #2;
    endtask
    task automatic pulse_arm;
        arm = 1'b1;
        step();
        arm = 1'b0;
        step();
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Oldest note against each accepted word; a stray word meets an empty queue
    always @(posedge core_clk) begin
        if (!rst && rd_valid === 1'b1 && rd_ready === 1'b1)
            chk({3'h0, read_last, rd_data}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF);
    end
    // Cycle ceiling against a hang
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    // Main sequence: charge, arm, trigger, wait done, read twice
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        {charge_active, trig, arm, read_start} = 4'h0;
        sample_in = {16{12'h800}};
        thr = 12'h800;
        lfsr = 32'h9C19A08E;
        repeat (3) @(posedge core_clk);
        #2 rst = 1'b0;
        chk({prefire_chan, prefire_fault, capture_done, state}, 16'h0000);
        sample_in[5*SW+:SW] = 12'h801;
        sample_in[11*SW+:SW] = 12'h801;
        sample_in[12*SW+:SW] = 12'hFFF;
        charge_active = 1'b1;
        repeat (3) step();
        chk({prefire_chan, prefire_fault}, 16'h1041);
        pulse_arm();
        chk({prefire_chan, prefire_fault}, 16'h1041);
        sample_in = {16{12'h800}};
        pulse_arm();
        chk({prefire_chan, prefire_fault}, 16'h0000);
        thr = 12'hFFF;
        for (int i = 0; i < 160; i++) begin
            lfsr = nxt(lfsr);
            mem[i] = lfsr[11:0];
        end
        for (int c = 0; c < 16; c++) sample_in[c*SW+:SW] = mem[c];
        trig = 1'b1;
        step();
        k = 0;
        // New frame values land mid-frame; a second trigger and a read request are refused
        while (state === WFCAP_RECORD && k < 60) begin
            if (k % 5 == 2 && k < 45)
                for (int c = 0; c < 16; c++) sample_in[c*SW+:SW] = mem[(k/5+1)*16+c];
            trig = (k < 20 || k > 22);
            read_start = (k == 30);
            if (k == 10) chk(capture_busy, 16'h0001);
            step();
            k++;
        end
        chk(16'(k), 16'h0032);
        chk({capture_done, capture_busy}, 16'h0002);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 160; i++) exp_q.push_back({3'h0, i == 159, mem[i]});
            read_start = 1'b1;
            step();
            read_start = 1'b0;
            for (k = 0; k < 1500 && exp_q.size() > 0; k++) step();
            repeat (4) step();
            chk(16'(exp_q.size()), 16'h0000);
        end
        // Charging over, so the rearm leaves the unit idle instead of watching again
        charge_active = 1'b0;
        pulse_arm();
        chk({capture_done, state}, 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
